// ===== test/tb_touch_threshold_recal_config.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb_touch_threshold_recal_config;
    logic ref_clk = 1'b0, sys_rst = 1'b1, nfd = 1'b0, stby = 1'b0;
    logic [2:0] sv = 3'h0, negr, bup, ssel, ren = 3'h6;
    logic signed [7:0] d1 = 8'sh00;
    logic scl, sda, got, sda_oe_n;
    logic [7:0] e, t, badj;
    int num_errors = 0, checked = 0, npul = 0, nbu = 0, n;
    logic [31:0] seed = 32'h3534;
    logic [7:0] exp_q[$];
    logic [7:0] ra[7] = '{8'h2f, 8'h30, 8'h31, 8'h32, 8'h38, 8'h40, 8'h43};
    logic [7:0] rv[7] = '{8'h8a, 8'h40, 8'h40, 8'h40, 8'h01, 8'h00, 8'h40};
    int nt[4] = '{8, 12, 16, 20};
    always #20 ref_clk = ~ref_clk;
    ttrc_config i_ttrc_config (.ref_clk, .sys_rst, .scl_in(scl), .sda_in(sda),
        .sda_out(), .sda_oe_n, .sense_cycle_done(sv[0]), .standby_active(stby),
        .noise_filter_disable(nfd), .recal_enable(ren), .sample_valid(sv),
        .delta_one(d1), .delta_two(8'sh00), .delta_three(8'sh00),
        .touch_status(), .noise_status(), .negative_recal(negr),
        .base_update(bup), .base_adjust_one(badj), .base_adjust_two(),
        .base_adjust_three(), .standby_monitor(), .sample_select(ssel));
    ttrc_host i_host (.ref_clk, .sda_oe_n, .scl, .sda, .got, .rdata());
    // Oldest note against each read result
    always @(posedge got) begin
        e = exp_q.pop_front();
        `CHK("rdata", e, i_host.rdata)
    end
    always @(posedge ref_clk) if (negr[0]) npul++;
    always @(posedge ref_clk) if (bup[0]) nbu++;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        exp_q.push_back(v);
        i_host.rd(a);
    endtask
    task automatic samp(input logic signed [7:0] d);
        @(negedge ref_clk) sv = 3'h1;
        d1 = d;
        @(negedge ref_clk) sv = 3'h0;
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        num_errors++;
        close_out();
    end
    initial begin
        repeat (6) @(negedge ref_clk);
        sys_rst = 1'b0;
        foreach (ra[i]) rd(ra[i], rv[i]);
        rd(8'h44, 8'h00);
        i_host.wr(8'h38, 8'hff);
        rd(8'h38, 8'h03);
        $display("register test done");
        seed = lfsr(seed);
        t = seed[7:0] | 8'h80;
        i_host.wr(8'h30, t);
        for (int i = 0; i < 3; i++) rd(8'(8'h30 + i), t & 8'h7f);
        i_host.wr(8'h31, 8'h11);
        rd(8'h31, 8'h11);
        rd(8'h30, t & 8'h7f);
        i_host.wr(8'h2f, 8'h02);
        i_host.wr(8'h30, 8'h20);
        rd(8'h31, 8'h11);
        i_host.wr(8'h32, 8'h33);
        rd(8'h32, 8'h33);
        $display("threshold test done");
        for (int c = 0; c < 4; c++) begin
            i_host.wr(8'h38, 8'(c));
            samp(8'(nt[c] + 1));
            rd(8'h0a, 8'h01);
            samp(8'(nt[c]));
            rd(8'h0a, 8'h00);
        end
        samp(8'sh21);
        rd(8'h03, 8'h01);
        samp(8'sh20);
        rd(8'h03, 8'h00);
        nfd = 1'b1;
        samp(8'sh1f);
        rd(8'h0a, 8'h00);
        nfd = 1'b0;
        stby = 1'b1;
        samp(8'sh21);
        rd(8'h03, 8'h00);
        i_host.wr(8'h40, 8'hff);
        rd(8'h40, 8'h07);
        samp(8'sh40);
        rd(8'h03, 8'h00);
        samp(8'sh41);
        rd(8'h03, 8'h01);
        stby = 1'b0;
        $display("sense test done");
        for (int c = 0; c < 4; c++) begin
            i_host.wr(8'h2f, 8'(c << 3));
            `CHK("sel", 3'h0, ssel)
            samp(8'sh00);
            npul = 0;
            n = (c == 3) ? 32 : (8 << c);
            repeat (n - 1) samp(-8'sh05);
            `CHK("neg early", 0, npul)
            samp(-8'sh05);
            repeat (2) @(negedge ref_clk);
            `CHK("neg pulse", (c < 3) ? 1 : 0, npul)
        end
        for (int k = 0; k < 2; k++) begin
            i_host.wr(8'h2f, k ? 8'h60 : 8'h00);
            samp(8'sh00);
            npul = 0;
            repeat (4) samp(-8'sh05);
            samp(8'sh1e);
            repeat (4) samp(-8'sh05);
            repeat (2) @(negedge ref_clk);
            `CHK("neg keep", k, npul)
        end
        i_host.wr(8'h2f, 8'h18);
        `CHK("upd off", 0, nbu)
        ren = 3'h7;
        nbu = 0;
        samp(8'sh1e);
        repeat (32) samp(-8'sh05);
        repeat (2) @(negedge ref_clk);
        `CHK("upd", 1, nbu > 0)
        `CHK("adj", 8'hfb, badj)
        `CHK("ack", 0, i_host.bad_ack)
        $display("negative run test done");
        close_out();
    end
endmodule
`default_nettype wire

// ===== test/ttrc_host.sv
`timescale 1ns/100ps
`default_nettype none
module ttrc_host #(
    parameter logic [6:0] DEV = 7'h2a
) (
    input wire logic ref_clk,
    input wire logic sda_oe_n,
    output logic scl,
    output logic sda,
    output logic got,
    output logic [7:0] rdata
);
    logic sda_m = 1'b1;
    int bad_ack = 0;
    initial scl = 1'b1;
    initial got = 1'b0;
    assign sda = sda_m & sda_oe_n;
    task automatic w;
        repeat (5) @(negedge ref_clk);
    endtask
    task automatic start;
        sda_m = 1'b1; w(); scl = 1'b1; w(); sda_m = 1'b0; w(); scl = 1'b0; w();
    endtask
    task automatic stop;
        sda_m = 1'b0; w(); scl = 1'b1; w(); sda_m = 1'b1; w();
    endtask
    // Nine bits, MSB first, SDA moved only while SCL low
    task automatic xfer(input logic [8:0] s, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_m = s[i]; w(); scl = 1'b1; w();
            r = {r[7:0], sda};
            scl = 1'b0; w();
        end
    endtask
    task automatic wbyte(input logic [7:0] d);
        logic [8:0] r;
        xfer({d, 1'b1}, r);
        if (r[0] !== 1'b0) bad_ack++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start(); wbyte({DEV, 1'b0}); wbyte(a); wbyte(d); stop();
    endtask
    // Pointer write, repeated start, one byte read and NACK
    task automatic rd(input logic [7:0] a);
        logic [8:0] r;
        start(); wbyte({DEV, 1'b0}); wbyte(a); start(); wbyte({DEV, 1'b1});
        xfer(9'h1ff, r); stop();
        rdata = r[8:1]; got = 1'b1; w(); got = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== test/ttrc_props.sv
`timescale 1ns/100ps
`default_nettype none
module ttrc_props (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic sda_out,
    input wire logic standby_active,
    input wire logic noise_filter_disable,
    input wire logic [2:0] recal_enable,
    input wire logic [2:0] sample_valid,
    input wire logic signed [7:0] delta_one,
    input wire logic [2:0] touch_status,
    input wire logic [2:0] noise_status,
    input wire logic [2:0] negative_recal,
    input wire logic [2:0] base_update,
    input wire logic [2:0] standby_monitor
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_od; sda_out == 1'b0; endproperty
    a_od: assert property (p_od) else $error("sda_out high");
    property p_neg_pulse; negative_recal[0] |=> !negative_recal[0]; endproperty
    a_neg_pulse: assert property (p_neg_pulse)
        else $error("long neg");
    property p_neg_cause;
        $rose(negative_recal[0]) |-> $past(sample_valid[0] && delta_one[7]);
    endproperty
    a_neg_cause: assert property (p_neg_cause)
        else $error("neg cause");
    property p_base_en; base_update[0] |-> $past(recal_enable[0]); endproperty
    a_base_en: assert property (p_base_en) else $error("base off");
    property p_excl; !(touch_status[0] && noise_status[0]); endproperty
    a_excl: assert property (p_excl) else $error("touch and noise");
    property p_filt;
        noise_filter_disable && sample_valid[0]
            && (!standby_active || standby_monitor[0]) |=> !noise_status[0];
    endproperty
    a_filt: assert property (p_filt)
        else $error("noise unfiltered");
    property p_hold;
        !sample_valid[0] |=> $stable(touch_status[0])
            && $stable(noise_status[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("status moved");
    property p_neg_touch;
        sample_valid[0] && delta_one[7] && !standby_active |=> !touch_status[0];
    endproperty
    a_neg_touch: assert property (p_neg_touch)
        else $error("neg touch");
    property p_stby;
        standby_active && !standby_monitor[0] && sample_valid[0]
            |=> $stable(touch_status[0]);
    endproperty
    a_stby: assert property (p_stby) else $error("standby taken");
endmodule
bind ttrc_config ttrc_props i_ttrc_props (.ref_clk, .sys_rst, .sda_out,
    .standby_active, .noise_filter_disable, .recal_enable, .sample_valid,
    .delta_one, .touch_status, .noise_status, .negative_recal, .base_update,
    .standby_monitor);
`default_nettype wire

// ===== verilog/ttrc_config.sv
`timescale 1ns/100ps
`default_nettype none
`include "ttrc_regs.svh"
module ttrc_config #(
    // Slave address, value arbitrary
    parameter logic [6:0] DEVICE_ADDRESS = 7'h2a
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic sense_cycle_done,
    input wire logic standby_active,
    input wire logic noise_filter_disable,
    input wire logic [2:0] recal_enable,
    input wire logic [2:0] sample_valid,
    input wire logic signed [7:0] delta_one,
    input wire logic signed [7:0] delta_two,
    input wire logic signed [7:0] delta_three,
    output logic [2:0] touch_status,
    output logic [2:0] noise_status,
    output logic [2:0] negative_recal,
    output logic [2:0] base_update,
    output logic [7:0] base_adjust_one,
    output logic [7:0] base_adjust_two,
    output logic [7:0] base_adjust_three,
    output logic [2:0] standby_monitor,
    output logic [2:0] sample_select
);
    ttrc_pkg::ttrc_top_t q;
    ttrc_pkg::ttrc_top_t next_q;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic update_pulse;
    logic [7:0] rd_data;
    logic [2:0] touch_vec;
    logic [2:0] noise_vec;
    logic [2:0][7:0] delta_vec;
    logic [2:0][7:0] adjust_vec;

    assign delta_vec = {delta_three, delta_two, delta_one};

    ////////////////////////////////////////////////////////////////////
    // Bus line events, from synchronised copies only
    assign scl_rise = q.scl_s2 && !q.scl_d;
    assign scl_fall = !q.scl_s2 && q.scl_d;
    assign bus_start = q.scl_s2 && q.scl_d && q.sda_d && !q.sda_s2;
    assign bus_stop = q.scl_s2 && q.scl_d && !q.sda_d && q.sda_s2;

    always_comb begin
        case (q.ptr)
            `TTRC_ADDR_TOUCH_STATUS: rd_data = {5'h00, touch_vec};
            `TTRC_ADDR_NOISE_STATUS: rd_data = {5'h00, noise_vec};
            `TTRC_ADDR_RECAL_CFG: rd_data = q.recal_cfg;
            `TTRC_ADDR_THR_ONE: rd_data = {1'b0, q.thr[0]};
            `TTRC_ADDR_THR_TWO: rd_data = {1'b0, q.thr[1]};
            `TTRC_ADDR_THR_THREE: rd_data = {1'b0, q.thr[2]};
            `TTRC_ADDR_NOISE_SEL: rd_data = {6'h00, q.noise_sel};
            `TTRC_ADDR_STBY_EN: rd_data = {5'h00, q.stby_en};
            `TTRC_ADDR_STBY_THR: rd_data = {1'b0, q.stby_thr};
            default: rd_data = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Serial slave and register file
    always_comb begin
        next_q = q;
        next_q.scl_s1 = scl_in;
        next_q.scl_s2 = q.scl_s1;
        next_q.scl_d = q.scl_s2;
        next_q.sda_s1 = sda_in;
        next_q.sda_s2 = q.sda_s1;
        next_q.sda_d = q.sda_s2;
        next_q.sda_out = 1'b0;
        if (bus_start) begin
            next_q.state = ttrc_pkg::TTRC_ADDR;
            next_q.bitcnt = 4'h0;
            next_q.have_ptr = 1'b0;
            next_q.sda_oe_n = 1'b1;
        end else if (bus_stop) begin
            next_q.state = ttrc_pkg::TTRC_IDLE;
            next_q.sda_oe_n = 1'b1;
        end else if (scl_rise) begin
            // Sample data bits on rising clock
            case (q.state)
                ttrc_pkg::TTRC_ADDR, ttrc_pkg::TTRC_RX: begin
                    next_q.shift = {q.shift[6:0], q.sda_s2};
                    next_q.bitcnt = q.bitcnt + 4'h1;
                end
                ttrc_pkg::TTRC_TX_ACK: begin
                    next_q.nack = q.sda_s2;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            // Change our drive only while clock is low
            case (q.state)
                ttrc_pkg::TTRC_ADDR: begin
                    if (q.bitcnt == 4'h8) begin
                        if (q.shift[7:1] == DEVICE_ADDRESS) begin
                            next_q.rw = q.shift[0];
                            next_q.sda_oe_n = 1'b0;
                            next_q.state = ttrc_pkg::TTRC_ADDR_ACK;
                        end else begin
                            next_q.state = ttrc_pkg::TTRC_IDLE;
                        end
                    end
                end
                ttrc_pkg::TTRC_ADDR_ACK: begin
                    next_q.bitcnt = 4'h0;
                    if (q.rw) begin
                        next_q.shift = rd_data;
                        next_q.sda_oe_n = rd_data[7];
                        next_q.state = ttrc_pkg::TTRC_TX;
                    end else begin
                        next_q.sda_oe_n = 1'b1;
                        next_q.state = ttrc_pkg::TTRC_RX;
                    end
                end
                ttrc_pkg::TTRC_RX: begin
                    if (q.bitcnt == 4'h8) begin
                        next_q.sda_oe_n = 1'b0;
                        next_q.state = ttrc_pkg::TTRC_RX_ACK;
                        if (!q.have_ptr) begin
                            next_q.ptr = q.shift;
                            next_q.have_ptr = 1'b1;
                        end else begin
                            next_q.ptr = q.ptr + 8'h01;
                            case (q.ptr)
                                `TTRC_ADDR_RECAL_CFG: begin
                                    next_q.recal_cfg = q.shift;
                                end
                                `TTRC_ADDR_THR_ONE: begin
                                    next_q.thr[0] = q.shift[6:0];
                                    if (q.recal_cfg[`TTRC_BIT_BCAST]) begin
                                        next_q.thr[1] = q.shift[6:0];
                                        next_q.thr[2] = q.shift[6:0];
                                    end
                                end
                                `TTRC_ADDR_THR_TWO: begin
                                    next_q.thr[1] = q.shift[6:0];
                                end
                                `TTRC_ADDR_THR_THREE: begin
                                    next_q.thr[2] = q.shift[6:0];
                                end
                                `TTRC_ADDR_NOISE_SEL: begin
                                    next_q.noise_sel = q.shift[1:0];
                                end
                                `TTRC_ADDR_STBY_EN: begin
                                    next_q.stby_en = q.shift[2:0];
                                end
                                `TTRC_ADDR_STBY_THR: begin
                                    next_q.stby_thr = q.shift[6:0];
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end
                ttrc_pkg::TTRC_RX_ACK: begin
                    next_q.sda_oe_n = 1'b1;
                    next_q.bitcnt = 4'h0;
                    next_q.state = ttrc_pkg::TTRC_RX;
                end
                ttrc_pkg::TTRC_TX: begin
                    if (q.bitcnt == 4'h7) begin
                        next_q.sda_oe_n = 1'b1;
                        next_q.ptr = q.ptr + 8'h01;
                        next_q.state = ttrc_pkg::TTRC_TX_ACK;
                    end else begin
                        next_q.shift = {q.shift[6:0], 1'b0};
                        next_q.sda_oe_n = q.shift[6];
                        next_q.bitcnt = q.bitcnt + 4'h1;
                    end
                end
                ttrc_pkg::TTRC_TX_ACK: begin
                    next_q.bitcnt = 4'h0;
                    if (q.nack) begin
                        next_q.state = ttrc_pkg::TTRC_IDLE;
                    end else begin
                        next_q.shift = rd_data;
                        next_q.sda_oe_n = rd_data[7];
                        next_q.state = ttrc_pkg::TTRC_TX;
                    end
                end
                default: begin
                    next_q.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register with documented reset values
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.state <= ttrc_pkg::TTRC_IDLE;
            q.scl_s1 <= 1'b1;
            q.scl_s2 <= 1'b1;
            q.scl_d <= 1'b1;
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
            q.sda_d <= 1'b1;
            q.sda_oe_n <= 1'b1;
            q.recal_cfg <= `TTRC_RST_RECAL_CFG;
            q.thr <= {3{`TTRC_RST_THR}};
            q.noise_sel <= `TTRC_RST_NOISE_SEL;
            q.stby_en <= `TTRC_RST_STBY_EN;
            q.stby_thr <= `TTRC_RST_STBY_THR;
        end else begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Common update timer
    ttrc_update_timer u_timer (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sense_cycle_done(sense_cycle_done),
        .period_select(q.recal_cfg[`TTRC_CAL_HI:`TTRC_CAL_LO]),
        .update_pulse(update_pulse)
    );

    // Per-input decision logic
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_chan
            logic in_stby;
            logic take;
            logic [6:0] use_thr;
            // gate inputs not monitored in standby
            assign in_stby = standby_active && q.stby_en[gi];
            assign take = sample_valid[gi]
                && (!standby_active || q.stby_en[gi]);
            assign use_thr = in_stby ? q.stby_thr : q.thr[gi];
            ttrc_input_channel u_chan (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .sample_valid(take),
                .delta(delta_vec[gi]),
                .threshold(use_thr),
                .noise_percent(q.noise_sel),
                .noise_filter_disable(noise_filter_disable),
                .keep_intermediate_data(q.recal_cfg[`TTRC_BIT_KEEP_INT]),
                .keep_negative_counter(q.recal_cfg[`TTRC_BIT_KEEP_NEG]),
                .negative_run_length_select(
                    q.recal_cfg[`TTRC_RUN_HI:`TTRC_RUN_LO]),
                .sample_select(q.recal_cfg[`TTRC_CAL_HI:`TTRC_CAL_LO]),
                .update_pulse(update_pulse),
                .recal_enable(recal_enable[gi]),
                .touch(touch_vec[gi]),
                .noise(noise_vec[gi]),
                .neg_recal(negative_recal[gi]),
                .base_update(base_update[gi]),
                .base_adjust(adjust_vec[gi])
            );
        end
    endgenerate

    // Outputs
    assign sda_out = q.sda_out;
    assign sda_oe_n = q.sda_oe_n;
    assign touch_status = touch_vec;
    assign noise_status = noise_vec;
    assign base_adjust_one = adjust_vec[0];
    assign base_adjust_two = adjust_vec[1];
    assign base_adjust_three = adjust_vec[2];
    assign standby_monitor = q.stby_en;
    assign sample_select = q.recal_cfg[`TTRC_CAL_HI:`TTRC_CAL_LO];
endmodule
`default_nettype wire

// ===== verilog/ttrc_input_channel.sv
`timescale 1ns/100ps
`default_nettype none
`include "ttrc_regs.svh"
module ttrc_input_channel (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic sample_valid,
    input wire logic signed [7:0] delta,
    input wire logic [6:0] threshold,
    input wire logic [1:0] noise_percent,
    input wire logic noise_filter_disable,
    input wire logic keep_intermediate_data,
    input wire logic keep_negative_counter,
    input wire logic [1:0] negative_run_length_select,
    input wire logic [2:0] sample_select,
    input wire logic update_pulse,
    input wire logic recal_enable,
    output logic touch,
    output logic noise,
    output logic neg_recal,
    output logic base_update,
    output logic [7:0] base_adjust
);
    ttrc_pkg::ttrc_chan_t q;
    ttrc_pkg::ttrc_chan_t next_q;
    logic [6:0] noise_thr;
    logic [5:0] run_len;
    logic [3:0] log_n;
    logic [7:0] last_idx;
    logic is_touch;
    logic is_spike;
    logic [5:0] cnt_inc;
    logic signed [16:0] acc_new;

    // noise threshold as fraction of threshold
    always_comb begin
        case (noise_percent)
            2'h0: noise_thr = threshold >> 2;
            2'h1: noise_thr = (threshold >> 2) + (threshold >> 3);
            2'h2: noise_thr = threshold >> 1;
            default: noise_thr = (threshold >> 1) + (threshold >> 3);
        endcase
    end

    always_comb begin
        case (negative_run_length_select)
            2'h0: run_len = `TTRC_RUN_LEN_0;
            2'h1: run_len = `TTRC_RUN_LEN_1;
            default: run_len = `TTRC_RUN_LEN_2;
        endcase
    end

    always_comb begin
        if (sample_select > 3'h4) begin
            log_n = `TTRC_LOG_MAX;
        end else begin
            log_n = {1'b0, sample_select} + 4'h4;
        end
        last_idx = 8'((9'h001 << log_n) - 9'h001);
    end

    assign is_touch = delta > $signed({1'b0, threshold});
    // spike between noise and touch levels
    assign is_spike = !is_touch && !noise_filter_disable
        && (delta > $signed({1'b0, noise_thr}));
    assign cnt_inc = q.negcnt + 6'h01;
    assign acc_new = q.acc + 17'(delta);

    always_comb begin
        next_q = q;
        next_q.neg_recal = 1'b0;
        next_q.base_update = 1'b0;
        if (sample_valid) begin
            next_q.touch = is_touch;
            next_q.noise = is_spike;
            if (delta < 0) begin
                next_q.negcnt = cnt_inc;
            end else begin
                next_q.negcnt = 6'h00;
            end
            // noise clears negative run unless kept
            if (is_spike) begin
                next_q.negcnt = keep_negative_counter ? q.negcnt : 6'h00;
            end else if (delta < 0 && cnt_inc >= run_len
                && negative_run_length_select != `TTRC_RUN_OFF) begin
                next_q.neg_recal = 1'b1;
                next_q.negcnt = 6'h00;
            end
            if (is_spike) begin
                if (!keep_intermediate_data) begin
                    next_q.acc = '0;
                    next_q.scount = 8'h00;
                end
            end else if (!is_touch) begin
                if (q.scount >= last_idx) begin
                    next_q.avg = 8'(acc_new >>> log_n);
                    next_q.avg_ready = 1'b1;
                    next_q.acc = '0;
                    next_q.scount = 8'h00;
                end else begin
                    next_q.acc = acc_new;
                    next_q.scount = q.scount + 8'h01;
                end
            end
        end
        if (update_pulse && q.avg_ready && recal_enable) begin
            next_q.base_update = 1'b1;
            next_q.avg_ready = 1'b0;
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign touch = q.touch;
    assign noise = q.noise;
    assign neg_recal = q.neg_recal;
    assign base_update = q.base_update;
    assign base_adjust = q.avg;
endmodule
`default_nettype wire

// ===== verilog/ttrc_pkg.sv
`default_nettype none
package ttrc_pkg;

    // Serial slave states
    typedef enum logic [2:0] {
        TTRC_IDLE = 3'b000,
        TTRC_ADDR = 3'b001,
        TTRC_ADDR_ACK = 3'b010,
        TTRC_RX = 3'b011,
        TTRC_RX_ACK = 3'b100,
        TTRC_TX = 3'b101,
        TTRC_TX_ACK = 3'b110
    } ttrc_state_t;

    // Top-level state
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
        logic sda_s1;
        logic sda_s2;
        logic sda_d;
        ttrc_state_t state;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic have_ptr;
        logic rw;
        logic nack;
        logic sda_oe_n;
        logic sda_out;
        logic [7:0] recal_cfg;
        logic [2:0][6:0] thr;
        logic [1:0] noise_sel;
        logic [2:0] stby_en;
        logic [6:0] stby_thr;
    } ttrc_top_t;

    // Per-input decision state
    typedef struct packed {
        logic touch;
        logic noise;
        logic [5:0] negcnt;
        logic neg_recal;
        logic signed [16:0] acc;
        logic [7:0] scount;
        logic [7:0] avg;
        logic avg_ready;
        logic base_update;
    } ttrc_chan_t;

    // Update period timer state
    typedef struct packed {
        logic [12:0] cnt;
        logic pulse;
    } ttrc_timer_t;

endpackage
`default_nettype wire

// ===== verilog/ttrc_regs.svh
`ifndef TTRC_REGS_SVH
`define TTRC_REGS_SVH

////////////////////////////////////////////////////////////////////////
// Register offsets
`define TTRC_ADDR_TOUCH_STATUS 8'h03
`define TTRC_ADDR_NOISE_STATUS 8'h0a
`define TTRC_ADDR_RECAL_CFG 8'h2f
`define TTRC_ADDR_THR_ONE 8'h30
`define TTRC_ADDR_THR_TWO 8'h31
`define TTRC_ADDR_THR_THREE 8'h32
`define TTRC_ADDR_NOISE_SEL 8'h38
`define TTRC_ADDR_STBY_EN 8'h40
`define TTRC_ADDR_STBY_THR 8'h43

////////////////////////////////////////////////////////////////////////
// Reset values
`define TTRC_RST_RECAL_CFG 8'h8a
`define TTRC_RST_THR 7'h40
`define TTRC_RST_NOISE_SEL 2'h1
`define TTRC_RST_STBY_EN 3'h0
`define TTRC_RST_STBY_THR 7'h40

////////////////////////////////////////////////////////////////////////
// Field positions of the recalibration configuration
`define TTRC_BIT_BCAST 7
`define TTRC_BIT_KEEP_INT 6
`define TTRC_BIT_KEEP_NEG 5
`define TTRC_RUN_HI 4
`define TTRC_RUN_LO 3
`define TTRC_CAL_HI 2
`define TTRC_CAL_LO 0

////////////////////////////////////////////////////////////////////////
// Counts, in sensing samples or sensing cycles
`define TTRC_RUN_LEN_0 6'h08
`define TTRC_RUN_LEN_1 6'h10
`define TTRC_RUN_LEN_2 6'h20
`define TTRC_RUN_OFF 2'h3
`define TTRC_UPD_BASE 13'h0010
`define TTRC_UPD_1024 13'h0400
`define TTRC_UPD_2048 13'h0800
`define TTRC_UPD_4096 13'h1000
`define TTRC_LOG_MAX 4'h8

`endif

// ===== verilog/ttrc_update_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "ttrc_regs.svh"
module ttrc_update_timer (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic sense_cycle_done,
    input wire logic [2:0] period_select,
    output logic update_pulse
);
    ttrc_pkg::ttrc_timer_t q;
    ttrc_pkg::ttrc_timer_t next_q;
    logic [12:0] period;

    always_comb begin
        case (period_select)
            3'h5: period = `TTRC_UPD_1024;
            3'h6: period = `TTRC_UPD_2048;
            3'h7: period = `TTRC_UPD_4096;
            default: period = `TTRC_UPD_BASE << period_select;
        endcase
    end

    always_comb begin
        next_q = q;
        next_q.pulse = 1'b0;
        if (sense_cycle_done) begin
            if (q.cnt + 13'h0001 >= period) begin
                next_q.cnt = 13'h0000;
                next_q.pulse = 1'b1;
            end else begin
                next_q.cnt = q.cnt + 13'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign update_pulse = q.pulse;
endmodule
`default_nettype wire
